// *** logic/smc_pkg.sv ***
// Constants, field layouts and carrier types of the synthesizer and modem configuration bank.
// Assumes a byte-wide register port with a 6-bit address driven from the mclk domain.
// Notes on behaviour
// RL1: Channel index times spacing adds to base.
// RL2: In receive, subtract scaled IF from base.
// RL3: Offset is signed, step crystal over 2^14.
// RL4: Carrier word bits 23:22 always read zero.
// RL5: Carrier is 24-bit base word times crystal/2^16.
// RL6: Decimation is 8*(4+mantissa)*2^exponent.
// RL7: Rate exponent is low nibble of first byte.
// RL8: Rate mantissa 9 bits, exponent 4 bits.
// RL9: Ninth mantissa bit is hidden one; 2^28 scale.
// RL10: All fields continuously presented to consumers.
package smc_pkg;

  localparam int ADDR_W = 6;
  localparam int DATA_W = 8;

  localparam logic [5:0] OFS_CHANNEL_NUMBER = 6'h0a;
  localparam logic [5:0] OFS_SYNTH_IF_CONTROL = 6'h0b;
  localparam logic [5:0] OFS_SYNTH_OFFSET_CONTROL = 6'h0c;
  localparam logic [5:0] OFS_CARRIER_WORD_HIGH = 6'h0d;
  localparam logic [5:0] OFS_CARRIER_WORD_MIDDLE = 6'h0e;
  localparam logic [5:0] OFS_CARRIER_WORD_LOW = 6'h0f;
  localparam logic [5:0] OFS_MODEM_BW_RATE_EXP = 6'h10;
  localparam logic [5:0] OFS_MODEM_RATE_MANTISSA = 6'h11;

  localparam logic [7:0] RST_CHANNEL_NUMBER = 8'h00;
  localparam logic [7:0] RST_SYNTH_IF_CONTROL = 8'h0f;
  localparam logic [7:0] RST_SYNTH_OFFSET_CONTROL = 8'h00;
  localparam logic [7:0] RST_CARRIER_WORD_HIGH = 8'h1e;
  localparam logic [7:0] RST_CARRIER_WORD_MIDDLE = 8'hc4;
  localparam logic [7:0] RST_CARRIER_WORD_LOW = 8'hec;
  localparam logic [7:0] RST_MODEM_BW_RATE_EXP = 8'h8c;
  localparam logic [7:0] RST_MODEM_RATE_MANTISSA = 8'h22;

  // Writable bit masks; bits outside a mask hold zero and read as zero.
  localparam logic [7:0] WMASK_FULL = 8'hff;
  localparam logic [7:0] WMASK_SYNTH_IF_CONTROL = 8'h3f;
  localparam logic [7:0] WMASK_CARRIER_WORD_HIGH = 8'h3f;

  localparam int IF_LSB = 0;
  localparam int IF_W = 5;
  localparam int BW_EXP_LSB = 6;
  localparam int BW_MANT_LSB = 4;
  localparam int BW_FIELD_W = 2;
  localparam int RATE_EXP_LSB = 0;
  localparam int RATE_EXP_W = 4;
  localparam int RATE_MANT_W = 9;

  // Frequency words carry two fraction bits below the crystal/2^16 step.
  localparam int FRAC_W = 2;
  localparam int CARRIER_BASE_WORD_W = 28;
  localparam int OFFSET_SHIFT = 16 - 14 + FRAC_W;
  localparam int IF_SHIFT = 16 - 10 + FRAC_W;
  localparam int SPACING_W = 16;
  localparam int DECIM_BASE = 8;
  localparam int DECIM_MANT_BIAS = 4;
  localparam int RATE_HIDDEN = 256;
  localparam int RATE_SCALE_LOG2 = 28;
  localparam int DECIM_W = 10;
  localparam int RATE_W = 24;

  typedef struct packed {
    logic [7:0] channel_index;
    logic [4:0] intermediate_carrier_base_word_setting;
    logic [7:0] synth_offset_value;
    logic [23:0] carrier_base_word;
    logic [1:0] bandwidth_exponent;
    logic [1:0] bandwidth_mantissa;
    logic [3:0] symbol_rate_exponent;
    logic [7:0] symbol_rate_mantissa;
  } smc_fields_t;

  typedef struct packed {
    logic [27:0] synth_carrier_base_word_word;
    logic [9:0] decimation_ratio;
    logic [23:0] rate_numerator;
  } smc_derived_t;

endpackage

// *** logic/smc_byte_reg.sv ***
// One byte-wide configuration register with a reset value and a writable-bit mask.
// Assumes write strobe and data come from logic on mclk.
`timescale 1ns/100ps
module smc_byte_reg #(
  parameter logic [7:0] RESET_VAL = 8'h00,
  parameter logic [7:0] WMASK = 8'hff
) (
  input wire logic mclk,
  input wire logic srst,
  input wire logic wr_en,
  input wire logic [7:0] wr_data,
  output logic [7:0] q
);
  logic [7:0] q_r;
  logic [7:0] q_nxt;

  // Masked bits are forced to zero so they can never be written or read back.
  always_comb begin
    q_nxt = q_r;
    if (wr_en) begin
      q_nxt = wr_data & WMASK; // RL4
    end
  end

  always_ff @(posedge mclk) begin
    if (srst) begin
      q_r <= RESET_VAL & WMASK;
    end else begin
      q_r <= q_nxt;
    end
  end

  assign q = q_r;
endmodule

// *** logic/smc_config_regs.sv ***
// Synthesizer and modem configuration bank with derived operating points.
// Assumes the serial configuration front end delivers byte writes and reads on mclk.
`timescale 1ns/100ps
module smc_config_regs (
  input wire logic mclk,
  input wire logic srst,
  input wire logic [smc_pkg::ADDR_W-1:0] cfg_addr,
  input wire logic [smc_pkg::DATA_W-1:0] cfg_wdata,
  input wire logic cfg_wr,
  input wire logic cfg_rd,
  output logic [smc_pkg::DATA_W-1:0] cfg_rdata,
  output logic cfg_rvalid,
  input wire logic rx_mode,
  input wire logic [smc_pkg::SPACING_W-1:0] channel_index_spacing_word,
  output smc_pkg::smc_fields_t fields,
  output smc_pkg::smc_derived_t derived
);
  import smc_pkg::*;

  localparam int NREG = 8;
  localparam logic [NREG*8-1:0] RESETS = {RST_MODEM_RATE_MANTISSA, RST_MODEM_BW_RATE_EXP,
    RST_CARRIER_WORD_LOW, RST_CARRIER_WORD_MIDDLE, RST_CARRIER_WORD_HIGH,
    RST_SYNTH_OFFSET_CONTROL, RST_SYNTH_IF_CONTROL, RST_CHANNEL_NUMBER};
  localparam logic [NREG*8-1:0] MASKS = {WMASK_FULL, WMASK_FULL, WMASK_FULL, WMASK_FULL,
    WMASK_CARRIER_WORD_HIGH, WMASK_FULL, WMASK_SYNTH_IF_CONTROL, WMASK_FULL};

  logic [7:0] regq [NREG];
  logic [NREG-1:0] wr_sel;
  logic in_range;
  logic [5:0] idx;

  assign idx = cfg_addr - OFS_CHANNEL_NUMBER;
  assign in_range = (cfg_addr >= OFS_CHANNEL_NUMBER) && (cfg_addr <= OFS_MODEM_RATE_MANTISSA);

  genvar g;
  generate
    for (g = 0; g < NREG; g++) begin : g_reg
      assign wr_sel[g] = cfg_wr && in_range && (idx == 6'(g));
      smc_byte_reg #(
        .RESET_VAL(RESETS[g*8 +: 8]),
        .WMASK(MASKS[g*8 +: 8])
      ) u_reg (
        .mclk(mclk),
        .srst(srst),
        .wr_en(wr_sel[g]),
        .wr_data(cfg_wdata),
        .q(regq[g])
      );
    end
  endgenerate

  // Read port: data registered one cycle after the read strobe; unmapped reads give zero.
  logic [7:0] rdata_r;
  logic [7:0] rdata_nxt;
  logic rvalid_r;
  logic rvalid_nxt;

  always_comb begin
    rdata_nxt = rdata_r;
    rvalid_nxt = cfg_rd;
    if (cfg_rd) begin
      rdata_nxt = in_range ? regq[idx[2:0]] : 8'h00;
    end
  end

  always_ff @(posedge mclk) begin
    if (srst) begin
      rdata_r <= 8'h00;
      rvalid_r <= 1'b0;
    end else begin
      rdata_r <= rdata_nxt;
      rvalid_r <= rvalid_nxt;
    end
  end

  assign cfg_rdata = rdata_r;
  assign cfg_rvalid = rvalid_r;

  // Fields go straight from the registers so consumers see a write on the next cycle.
  always_comb begin
    fields.channel_index = regq[0]; // RL10
    fields.intermediate_carrier_base_word_setting = regq[1][IF_LSB +: IF_W];
    fields.synth_offset_value = regq[2];
    fields.carrier_base_word = {regq[3], regq[4], regq[5]}; // RL5
    fields.bandwidth_exponent = regq[6][BW_EXP_LSB +: BW_FIELD_W];
    fields.bandwidth_mantissa = regq[6][BW_MANT_LSB +: BW_FIELD_W];
    fields.symbol_rate_exponent = regq[6][RATE_EXP_LSB +: RATE_EXP_W]; // RL7
    fields.symbol_rate_mantissa = regq[7];
  end

  // Derived values are registered, so they lag a register write by one extra cycle.
  logic [CARRIER_BASE_WORD_W-1:0] carrier_base_word_r;
  logic [CARRIER_BASE_WORD_W-1:0] carrier_base_word_nxt;
  logic [DECIM_W-1:0] decim_r;
  logic [DECIM_W-1:0] decim_nxt;
  logic [RATE_W-1:0] rate_r;
  logic [RATE_W-1:0] rate_nxt;
  logic [CARRIER_BASE_WORD_W-1:0] base_term;
  logic [CARRIER_BASE_WORD_W-1:0] channel_index_term;
  logic [CARRIER_BASE_WORD_W-1:0] off_term;
  logic [CARRIER_BASE_WORD_W-1:0] if_term;
  logic [RATE_MANT_W-1:0] mant9;

  always_comb begin
    base_term = CARRIER_BASE_WORD_W'({fields.carrier_base_word, {FRAC_W{1'b0}}});
    channel_index_term = CARRIER_BASE_WORD_W'(fields.channel_index) * CARRIER_BASE_WORD_W'(channel_index_spacing_word); // RL1
    off_term = CARRIER_BASE_WORD_W'(signed'({{(CARRIER_BASE_WORD_W-8){fields.synth_offset_value[7]}},
      fields.synth_offset_value}) <<< OFFSET_SHIFT); // RL3
    if_term = CARRIER_BASE_WORD_W'({fields.intermediate_carrier_base_word_setting, {IF_SHIFT{1'b0}}});
    carrier_base_word_nxt = base_term + channel_index_term + off_term;
    if (rx_mode) begin
      carrier_base_word_nxt = base_term + channel_index_term + off_term - if_term; // RL2
    end
    decim_nxt = DECIM_W'((DECIM_BASE * (DECIM_MANT_BIAS + fields.bandwidth_mantissa))
      << fields.bandwidth_exponent); // RL6
    mant9 = RATE_MANT_W'(RATE_HIDDEN) | RATE_MANT_W'(fields.symbol_rate_mantissa); // RL9
    rate_nxt = RATE_W'(RATE_W'(mant9) << fields.symbol_rate_exponent); // RL8
  end

  always_ff @(posedge mclk) begin
    if (srst) begin
      carrier_base_word_r <= '0;
      decim_r <= '0;
      rate_r <= '0;
    end else begin
      carrier_base_word_r <= carrier_base_word_nxt;
      decim_r <= decim_nxt;
      rate_r <= rate_nxt;
    end
  end

  // The rate output is the numerator; the consumer divides by 2^RATE_SCALE_LOG2 times crystal.
  assign derived.synth_carrier_base_word_word = carrier_base_word_r;
  assign derived.decimation_ratio = decim_r;
  assign derived.rate_numerator = rate_r;
endmodule

// *** testbench/smc_config_regs_sva.sv ***
// Port checks on the configuration bank.
// Assumes one mclk domain with srst synchronous.
`timescale 1ns/100ps
module smc_config_regs_sva (
  input wire logic mclk,
  input wire logic srst,
  input wire logic [smc_pkg::ADDR_W-1:0] cfg_addr,
  input wire logic [smc_pkg::DATA_W-1:0] cfg_wdata,
  input wire logic cfg_wr,
  input wire logic cfg_rd,
  input wire logic [smc_pkg::DATA_W-1:0] cfg_rdata,
  input wire logic cfg_rvalid,
  input wire logic rx_mode,
  input wire logic [smc_pkg::SPACING_W-1:0] channel_index_spacing_word,
  input wire smc_pkg::smc_fields_t fields,
  input wire smc_pkg::smc_derived_t derived
);
  import smc_pkg::*;
  default clocking cb @(posedge mclk); endclocking
  default disable iff (srst);
  sequence wr_at(logic [5:0] a);
    cfg_wr && cfg_addr == a;
  endsequence
  logic [27:0] fw;
  logic [9:0] dr;
  logic [23:0] rn;
  // Widen before multiplying so the channel product is not cut to 16 bits.
  assign fw = 28'({fields.carrier_base_word, 2'h0})
    + 28'(signed'(fields.synth_offset_value)) * 28'h000_0010
    + 28'(fields.channel_index) * 28'(channel_index_spacing_word)
    - (rx_mode ? 28'(fields.intermediate_carrier_base_word_setting) << 8 : 28'h000_0000);
  assign dr = (10'h020 + 10'(fields.bandwidth_mantissa) * 10'h008) << fields.bandwidth_exponent;
  assign rn = (24'h00_0100 + 24'(fields.symbol_rate_mantissa)) << fields.symbol_rate_exponent;
  rvalid_pulse_a: assert property (cfg_rd |=> cfg_rvalid) else $error("read not answered");
  rvalid_only_a: assert property (!cfg_rd |=> !cfg_rvalid) else $error("stray read valid");
  carrier_top_a: assert property (fields.carrier_base_word[23:22] == 2'h0)
    else $error("top bits");
  rd_top_a: assert property (cfg_rd && cfg_addr == OFS_CARRIER_WORD_HIGH
    |=> cfg_rdata[7:6] == 2'h0) else $error("high byte top bits read nonzero");
  channel_index_wr_a: assert property (wr_at(OFS_CHANNEL_NUMBER)
    |=> fields.channel_index == $past(cfg_wdata)) else $error("channel write lost");
  exp_wr_a: assert property (wr_at(OFS_MODEM_BW_RATE_EXP) |=>
    {fields.bandwidth_exponent, fields.bandwidth_mantissa, fields.symbol_rate_exponent}
    == $past(cfg_wdata)) else $error("exp");
  mant_wr_a: assert property (wr_at(OFS_MODEM_RATE_MANTISSA) |=>
    fields.symbol_rate_mantissa == $past(cfg_wdata)) else $error("rate mantissa write lost");
  carrier_base_word_word_a: assert property (1'b1 |=> derived.synth_carrier_base_word_word == $past(fw))
    else $error("synth word wrong");
  decim_a: assert property (1'b1 |=> derived.decimation_ratio == $past(dr))
    else $error("decim");
  rate_a: assert property (1'b1 |=> derived.rate_numerator == $past(rn))
    else $error("rate");
endmodule
bind smc_config_regs smc_config_regs_sva u_smc_config_regs_sva (.mclk(mclk), .srst(srst),
  .cfg_addr(cfg_addr), .cfg_wdata(cfg_wdata), .cfg_wr(cfg_wr), .cfg_rd(cfg_rd),
  .cfg_rdata(cfg_rdata), .cfg_rvalid(cfg_rvalid), .rx_mode(rx_mode),
  .channel_index_spacing_word(channel_index_spacing_word), .fields(fields), .derived(derived));

// *** testbench/smc_config_regs_tb.sv ***
// Bench for the configuration bank: reset values, masks, random traffic.
// Assumes the bound checker judges fields and derived words.
`timescale 1ns/100ps
module smc_config_regs_tb;
  import smc_pkg::*;
  logic mclk = 1'b0, srst = 1'b1, cfg_wr = 1'b0, cfg_rd = 1'b0, rx_mode = 1'b0, cfg_rvalid;
  logic [5:0] cfg_addr = 6'h00;
  logic [7:0] cfg_wdata = 8'h00, cfg_rdata;
  logic [15:0] channel_index_spacing_word = 16'h0000;
  smc_fields_t fields;
  smc_derived_t derived;
  logic [7:0] mdl [10:17];
  logic [7:0] exp_q [$];
  integer seed = 32'h2992_27db;
  int num_errors = 0, n_compared = 0;
  always #50 mclk = ~mclk;
  smc_config_regs u_smc_config_regs (.mclk(mclk), .srst(srst), .cfg_addr(cfg_addr),
    .cfg_wdata(cfg_wdata), .cfg_wr(cfg_wr), .cfg_rd(cfg_rd), .cfg_rdata(cfg_rdata),
    .cfg_rvalid(cfg_rvalid), .rx_mode(rx_mode), .channel_index_spacing_word(channel_index_spacing_word),
    .fields(fields), .derived(derived));
  task automatic give_verdict();
    $display("compared %0d, mismatches %0d", n_compared, num_errors);
    if (num_errors == 0 && n_compared > 0) $display("bench passed");
    else $display("bench failed");
    $finish;
  endtask
  task automatic cmp_rd(input logic [7:0] got, input logic [7:0] exp);
    n_compared++;
    if (got !== exp) begin
      $display("mismatch at %0t: read %h expected %h", $time, got, exp);
      num_errors++;
    end
  endtask
  task automatic cmp_fields();
    smc_fields_t want;
    want = {mdl[10], mdl[11][4:0], mdl[12], mdl[13], mdl[14], mdl[15], mdl[16], mdl[17]};
    n_compared++;
    if (fields !== want) begin
      $display("mismatch at %0t: fields %h expected %h", $time, fields, want);
      num_errors++;
    end
  endtask
  // Expected words follow the register model and the inputs that the bench last drove.
  task automatic cmp_derived();
    logic [27:0] f;
    logic [9:0] dd;
    logic [23:0] r;
    f = 28'({mdl[13][5:0], mdl[14], mdl[15], 2'h0}) + {{16{mdl[12][7]}}, mdl[12], 4'h0}
      + 28'(mdl[10]) * 28'(channel_index_spacing_word)
      - (rx_mode ? 28'(mdl[11][4:0]) << 8 : 28'h000_0000);
    dd = (10'h020 + 10'(mdl[16][5:4]) * 10'h008) << mdl[16][7:6];
    r = (24'h00_0100 + 24'(mdl[17])) << mdl[16][3:0];
    n_compared++;
    if (derived !== {f, dd, r}) begin
      $display("mismatch at %0t: derived %h expected %h", $time, derived, {f, dd, r});
      num_errors++;
    end
  endtask
  // One strobe stays up across back-to-back calls, cfg_wr for a write and cfg_rd for a read; only idle drops both.
  task automatic acc(input logic w, input logic [5:0] a, input logic [7:0] d);
    @(negedge mclk);
    cfg_wr = w;
    cfg_rd = ~w;
    cfg_addr = a;
    cfg_wdata = d;
    rx_mode = 1'($random(seed));
    channel_index_spacing_word = 16'($random(seed));
    if (w && a >= 6'h0a && a <= 6'h11) begin
      mdl[a] = d & ((a == 6'h0b || a == 6'h0d) ? 8'h3f : 8'hff);
    end
    if (!w) exp_q.push_back((a >= 6'h0a && a <= 6'h11) ? mdl[a] : 8'h00);
  endtask
  task automatic idle();
    @(negedge mclk);
    cfg_wr = 1'b0;
    cfg_rd = 1'b0;
  endtask
  task automatic do_reset();
    idle();
    srst = 1'b1;
    repeat (6) @(negedge mclk);
    srst = 1'b0;
    mdl = '{RST_CHANNEL_NUMBER, RST_SYNTH_IF_CONTROL, RST_SYNTH_OFFSET_CONTROL,
      RST_CARRIER_WORD_HIGH, RST_CARRIER_WORD_MIDDLE, RST_CARRIER_WORD_LOW,
      RST_MODEM_BW_RATE_EXP, RST_MODEM_RATE_MANTISSA};
  endtask
  task automatic read_all(input string name);
    for (int a = 9; a <= 18; a++) acc(1'b0, 6'(a), 8'h00);
    idle();
    cmp_fields();
    cmp_derived();
    $display("test %s done", name);
  endtask
  always @(negedge mclk) begin
    if (cfg_rvalid === 1'b1) begin
      if (exp_q.size() == 0) begin
        $display("mismatch at %0t: unexpected read answer", $time);
        num_errors++;
      end else cmp_rd(cfg_rdata, exp_q.pop_front());
    end
  end
  initial begin
    do_reset();
    read_all("reset_values");
    for (int i = 0; i < 2; i++) begin
      acc(1'b1, i ? 6'h0d : 6'h0b, 8'hff);
      acc(1'b0, i ? 6'h0d : 6'h0b, 8'h00);
    end
    $display("test masks done");
    repeat (300) acc(1'($random(seed)), 6'(8 + $unsigned($random(seed)) % 12), 8'($random(seed)));
    read_all("random_access");
    do_reset();
    read_all("mid_reset");
    repeat (3) @(negedge mclk);
    cmp_rd(8'(exp_q.size()), 8'h00);
    give_verdict();
  end
  initial begin
    repeat (2000) @(posedge mclk);
    num_errors++;
    give_verdict();
  end
endmodule
